// file: nvdac_ctrl.sv
// Nonvolatile data memory access controller behind special function registers
`timescale 1ns/1ns
// Summary of operation
// RULE1: 64 bytes at 0x00..0x3F, reached only byte-wise through registers.
// RULE2: Address register keeps six bits; top two read zero.
// RULE3: Data register keeps fetched byte until next read completes or software writes it.
// RULE4: Software reaches control register indirectly at 0x40 with bank one.
// RULE5: Program permit zero blocks starting any write.
// RULE6: Program go starts write; hardware clears it when write ends.
// RULE7: Program go without permit already set is ignored.
// RULE8: Fetch permit zero blocks starting any read.
// RULE9: Fetch go starts read; cleared when done, data then valid.
// RULE10: Fetch go without fetch permit starts nothing.
// RULE11: Software never sets both go bits, nor permit and go together.
// RULE12: Software loads address and data, then permit, then go next.
// RULE13: Software masks global interrupts around the permit-go sequence.
// RULE14: Write timed by asynchronous slow timer; completion delay not fixed.
// RULE15: Software ensures slow clock stable before writing.
// RULE16: Software leaves registers alone until a write completes.
// RULE17: Power-on clears all control bits.
// RULE18: Power-on selects bank zero.
// RULE19: Write end sets both flags; request needs all three enables.
// RULE20: Service clears only multi-function flag; software clears the other.
// RULE21: Read finishes in a fixed few cycles; go clears with data valid.
module nvdac_ctrl
    import nvdac_pkg::*;
#(
    parameter int WRITE_TICK_COUNT = WRITE_TICKS
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrite,
    input  wire logic       sfrRead,
    input  wire logic [7:0] sfrWdata,
    output logic      [7:0] sfrRdata,
    output logic            bankSelect,
    input  wire logic       slowClockIn,
    input  wire logic       globalIrqEnable,
    input  wire logic       irqService,
    output logic            irqRequest
);
    nvdac_state_e     state_r;
    logic [7:0]       memArray [NV_DEPTH];
    logic [NV_AW-1:0] nvAddr_r;
    logic [7:0]       nvByte_r;
    logic             programPermit_r;
    logic             programGo_r;
    logic             fetchPermit_r;
    logic             fetchGo_r;
    logic             bankSelect_r;
    logic             nvIrqEnable_r;
    logic             mfEnable_r;
    logic             nvIrqFlag_r;
    logic             mfFlag_r;
    logic [7:0]       sfrRdata_r;
    logic             irqRequest_r;
    logic [2:0]       readCnt_r;
    logic [7:0]       tickCnt_r;
    logic             slowSync1_r;
    logic             slowSync2_r;
    logic             slowPrev_r;
    logic             slowTick;
    logic             ctrlWrite;
    logic             startWrite;
    logic             startRead;
    logic             readDone;
    logic             writeDone;

    // Control register visible only with bank one selected
    assign ctrlWrite  = sfrWrite && sfrAddr == NV_CTRL_OFF && bankSelect_r;  // see RULE4
    assign startWrite = ctrlWrite && sfrWdata[PROGRAM_GO] && programPermit_r
                        && state_r == NVDAC_IDLE;  // see RULE5 see RULE7
    assign startRead  = ctrlWrite && sfrWdata[FETCH_GO_BIT] && fetchPermit_r
                        && !sfrWdata[PROGRAM_GO] && state_r == NVDAC_IDLE;  // see RULE8 see RULE10
    assign readDone   = state_r == NVDAC_READ && readCnt_r == READ_CYCLES - 3'd1;  // see RULE21
    assign writeDone  = state_r == NVDAC_WRITE && slowTick
                        && tickCnt_r == 8'(WRITE_TICK_COUNT - 1);  // see RULE14
    assign slowTick   = slowSync2_r && !slowPrev_r;

    // Bring the free-running slow timer clock into this domain
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            slowSync1_r <= 1'b0;
            slowSync2_r <= 1'b0;
            slowPrev_r  <= 1'b0;
        end else begin
            slowSync1_r <= slowClockIn;
            slowSync2_r <= slowSync1_r;
            slowPrev_r  <= slowSync2_r;
        end
    end

    // Cycle sequencer with read and write timers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r   <= NVDAC_IDLE;
            readCnt_r <= 3'd0;
            tickCnt_r <= 8'd0;
        end else begin
            case (state_r)
                NVDAC_IDLE: begin
                    readCnt_r <= 3'd0;
                    tickCnt_r <= 8'd0;
                    if (startWrite) begin
                        state_r <= NVDAC_WRITE;
                    end else if (startRead) begin
                        state_r <= NVDAC_READ;
                    end
                end
                NVDAC_READ: begin
                    readCnt_r <= readCnt_r + 3'd1;
                    if (readDone) begin
                        state_r <= NVDAC_IDLE;
                    end
                end
                NVDAC_WRITE: begin
                    if (slowTick) begin
                        tickCnt_r <= tickCnt_r + 8'd1;
                    end
                    if (writeDone) begin
                        state_r <= NVDAC_IDLE;
                    end
                end
                default: begin
                    state_r <= NVDAC_IDLE;
                end
            endcase
        end
    end

    // Byte storage, written when the timed cycle ends
    always_ff @(posedge clk) begin
        if (writeDone) begin
            memArray[nvAddr_r] <= nvByte_r;  // see RULE1 see RULE6
        end
    end

    // Address and data registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nvAddr_r <= '0;
            nvByte_r <= REG_RESET;
        end else begin
            if (sfrWrite && sfrAddr == NV_ADDR_OFF) begin
                nvAddr_r <= sfrWdata[NV_AW-1:0];  // see RULE2
            end
            if (readDone) begin
                nvByte_r <= memArray[nvAddr_r];  // see RULE3 see RULE9
            end else if (sfrWrite && sfrAddr == NV_BYTE_OFF) begin
                nvByte_r <= sfrWdata;
            end
        end
    end

    // Control bits; go bits are set by software and cleared by hardware
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            programPermit_r <= 1'b0;  // see RULE17
            fetchPermit_r   <= 1'b0;
            programGo_r     <= 1'b0;
            fetchGo_r       <= 1'b0;
        end else begin
            if (ctrlWrite) begin
                programPermit_r <= sfrWdata[PROGRAM_PERMT];
                fetchPermit_r   <= sfrWdata[FETCH_PERMIT];
            end
            if (startWrite) begin
                programGo_r <= 1'b1;  // see RULE6
            end else if (writeDone) begin
                programGo_r <= 1'b0;  // see RULE6
            end
            if (startRead) begin
                fetchGo_r <= 1'b1;  // see RULE9
            end else if (readDone) begin
                fetchGo_r <= 1'b0;  // see RULE21
            end
        end
    end

    // Bank select, cleared at power-on
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bankSelect_r <= 1'b0;  // see RULE18
        end else if (sfrWrite && sfrAddr == BANK_SEL_OFF) begin
            bankSelect_r <= sfrWdata == CTRL_BANK;
        end
    end

    // Interrupt enables and flags; a set beats a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nvIrqEnable_r <= 1'b0;
            mfEnable_r    <= 1'b0;
            nvIrqFlag_r   <= 1'b0;
            mfFlag_r      <= 1'b0;
            irqRequest_r  <= 1'b0;
        end else begin
            if (sfrWrite && sfrAddr == NV_IRQ_OFF) begin
                nvIrqEnable_r <= sfrWdata[IRQ_NV_EN];
                mfEnable_r    <= sfrWdata[IRQ_MF_EN];
                nvIrqFlag_r   <= sfrWdata[IRQ_NV_FLAG] || writeDone;  // see RULE20
                mfFlag_r      <= sfrWdata[IRQ_MF_FLAG] || writeDone;
            end else begin
                if (writeDone) begin
                    nvIrqFlag_r <= 1'b1;  // see RULE19
                end
                if (writeDone) begin
                    mfFlag_r <= 1'b1;  // see RULE19
                end else if (irqService) begin
                    mfFlag_r <= 1'b0;  // see RULE20
                end
            end
            irqRequest_r <= globalIrqEnable && nvIrqEnable_r && mfEnable_r
                            && nvIrqFlag_r && mfFlag_r;  // see RULE19
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sfrRdata_r <= REG_RESET;
        end else if (sfrRead) begin
            if (sfrAddr == NV_ADDR_OFF) begin
                sfrRdata_r <= {2'b00, nvAddr_r};  // see RULE2
            end else if (sfrAddr == NV_BYTE_OFF) begin
                sfrRdata_r <= nvByte_r;
            end else if (sfrAddr == NV_CTRL_OFF && bankSelect_r) begin
                sfrRdata_r <= {4'h0, programPermit_r, programGo_r, fetchPermit_r, fetchGo_r};
            end else if (sfrAddr == BANK_SEL_OFF) begin
                sfrRdata_r <= {7'h00, bankSelect_r};
            end else if (sfrAddr == NV_IRQ_OFF) begin
                sfrRdata_r <= {4'h0, mfFlag_r, nvIrqFlag_r, mfEnable_r, nvIrqEnable_r};
            end else begin
                sfrRdata_r <= REG_RESET;
            end
        end
    end

    assign sfrRdata   = sfrRdata_r;
    assign bankSelect = bankSelect_r;
    assign irqRequest = irqRequest_r;

    // Checks on the sequencer, storage and flags
    AST_ADDR_TOP_ZERO: assert property (@(posedge clk) disable iff (reset)
        sfrRead && sfrAddr == NV_ADDR_OFF |=> sfrRdata[7:6] == 2'b00)  // see RULE2
        else $error("address register top bits not zero");
    AST_WRITE_NEEDS_PERMIT: assert property (@(posedge clk) disable iff (reset)
        ctrlWrite && !programPermit_r |=> !$rose(programGo_r) && state_r != NVDAC_WRITE)  // see RULE7
        else $error("write started without permit");
    AST_READ_NEEDS_PERMIT: assert property (@(posedge clk) disable iff (reset)
        ctrlWrite && !fetchPermit_r && state_r == NVDAC_IDLE |=> state_r != NVDAC_READ)  // see RULE10
        else $error("read started without permit");
    AST_READ_BOUNDED: assert property (@(posedge clk) disable iff (reset)
        $rose(fetchGo_r) |-> fetchGo_r [*2] ##1 !fetchGo_r)  // see RULE21
        else $error("read cycle length wrong");
    AST_READ_DATA: assert property (@(posedge clk) disable iff (reset)
        $fell(fetchGo_r) |-> nvByte_r == memArray[nvAddr_r])  // see RULE9
        else $error("fetched byte not in data register");
    AST_BYTE_HELD: assert property (@(posedge clk) disable iff (reset)
        !readDone && !(sfrWrite && sfrAddr == NV_BYTE_OFF) |=> $stable(nvByte_r))  // see RULE3
        else $error("data register changed unprompted");
    AST_WRITE_STORES: assert property (@(posedge clk) disable iff (reset)
        $fell(programGo_r) |-> memArray[nvAddr_r] == nvByte_r && nvIrqFlag_r && mfFlag_r)  // see RULE19
        else $error("write end without store or flags");
    AST_IRQ_GATED: assert property (@(posedge clk) disable iff (reset)
        irqRequest |-> $past(globalIrqEnable && nvIrqEnable_r && mfEnable_r))  // see RULE19
        else $error("interrupt raised while masked");
    AST_SERVICE_CLEAR: assert property (@(posedge clk) disable iff (reset)
        irqService && !writeDone && !sfrWrite |=> !mfFlag_r && nvIrqFlag_r == $past(nvIrqFlag_r))  // see RULE20
        else $error("service did not clear only the shared flag");
endmodule

// file: nvdac_pkg.sv
// Constants shared by the nonvolatile data memory access controller
package nvdac_pkg;
    // Storage geometry
    localparam int NV_DEPTH = 64;
    localparam int NV_AW    = 6;

    // Special function register addresses (bank 0 unless noted)
    localparam logic [7:0] NV_ADDR_OFF  = 8'h1E;
    localparam logic [7:0] NV_BYTE_OFF  = 8'h1F;
    localparam logic [7:0] NV_CTRL_OFF  = 8'h40;  // Bank 1, indirect only
    localparam logic [7:0] BANK_SEL_OFF = 8'h04;
    localparam logic [7:0] NV_IRQ_OFF   = 8'h0C;
    localparam logic [7:0] CTRL_BANK    = 8'h01;

    // Control register fields
    localparam int FETCH_GO_BIT  = 0;
    localparam int FETCH_PERMIT  = 1;
    localparam int PROGRAM_GO    = 2;
    localparam int PROGRAM_PERMT = 3;

    // Interrupt register fields
    localparam int IRQ_NV_EN   = 0;
    localparam int IRQ_MF_EN   = 1;
    localparam int IRQ_NV_FLAG = 2;
    localparam int IRQ_MF_FLAG = 3;

    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;

    // Timing: read cycle length and write length in slow-timer ticks
    localparam logic [2:0] READ_CYCLES = 3'd2;
    localparam int         WRITE_TICKS = 4;

    // Cycle state
    typedef enum logic [1:0] {
        NVDAC_IDLE  = 2'b00,
        NVDAC_READ  = 2'b01,
        NVDAC_WRITE = 2'b10
    } nvdac_state_e;
endpackage

// file: eeprom_data_access_ctrl_test.sv
// Self-checking testbench for the nonvolatile data memory access controller
`timescale 1ns/1ns
module eeprom_data_access_ctrl_test;
    import nvdac_pkg::*;
    typedef struct {
        string      what;
        logic [7:0] value;
    } nvdac_note_s;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  sfrAddr = 8'h00;
    logic        sfrWrite = 1'b0;
    logic        sfrRead = 1'b0;
    logic [7:0]  sfrWdata = 8'h00;
    logic [7:0]  sfrRdata;
    logic        bankSelect;
    logic        slowClockIn = 1'b0;
    logic        globalIrqEnable = 1'b0;
    logic        irqService = 1'b0;
    logic        irqRequest;
    logic        noteRead = 1'b0;
    logic        rdTaken = 1'b0;
    logic [7:0]  mem [NV_DEPTH];
    logic [5:0]  addrs [6];
    logic [7:0]  got;
    logic [7:0]  d;
    int          err_count = 0;
    int          n_checks = 0;
    nvdac_note_s notes [$];
    nvdac_note_s head;
    // System clock and a slow timer clock unrelated in phase
    always #50 clk = ~clk;
    always #1570 slowClockIn = ~slowClockIn;
    nvdac_ctrl #(.WRITE_TICK_COUNT(2)) u_nvdac_ctrl (
        .clk(clk), .reset(reset), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
        .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .bankSelect(bankSelect), .slowClockIn(slowClockIn),
        .globalIrqEnable(globalIrqEnable), .irqService(irqService), .irqRequest(irqRequest));
    task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (exp !== seen) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One-cycle register write pulse
    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        @(negedge clk);
        sfrAddr  = adr;
        sfrWdata = dat;
        sfrWrite = 1'b1;
        @(negedge clk);
        sfrWrite = 1'b0;
    endtask
    // Register read; a noted read leaves its expected byte for the monitor
    task automatic rd(input logic [7:0] adr, input logic note, input string what, input logic [7:0] exp);
        @(negedge clk);
        sfrAddr  = adr;
        sfrRead  = 1'b1;
        noteRead = note;
        if (note) notes.push_back('{what, exp});
        @(negedge clk);
        sfrRead = 1'b0;
        got     = sfrRdata;
    endtask
    // Poll a go bit until hardware drops it, bounded
    task automatic wait_go_clear(input int bitPos);
        for (int i = 0; i < 300; i++) begin
            rd(NV_CTRL_OFF, 1'b0, "", 8'h00);
            if (got[bitPos] === 1'b0) return;
        end
        $display("CHECK FAILED go bit %0d expected 0 seen 1", bitPos);
        err_count++;
        print_verdict();
    endtask
    // Monitor: compare read data with the oldest note the cycle after the read
    always @(posedge clk) rdTaken <= sfrRead && noteRead;
    always @(negedge clk) begin
        if (rdTaken) begin
            head = notes.pop_front();
            compare(head.what, head.value, sfrRdata);
        end
    end
    initial begin
        void'($urandom(32'h5feab2fb));
        repeat (5) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        compare("bankSelect", 8'h00, {7'h00, bankSelect});
        rd(NV_ADDR_OFF, 1'b1, "addrReset", 8'h00);
        rd(NV_BYTE_OFF, 1'b1, "byteReset", 8'h00);
        wr(NV_CTRL_OFF, 8'h08);
        rd(NV_CTRL_OFF, 1'b1, "ctrlBank0", 8'h00);
        wr(BANK_SEL_OFF, CTRL_BANK);
        compare("bankSelect", 8'h01, {7'h00, bankSelect});
        rd(NV_CTRL_OFF, 1'b1, "ctrlReset", 8'h00);
        rd(NV_IRQ_OFF, 1'b1, "irqReset", 8'h00);
        wr(NV_ADDR_OFF, 8'hFF);
        rd(NV_ADDR_OFF, 1'b1, "addrMask", 8'h3F);
        // Go bits without their permits, and permit with go in one write
        wr(NV_CTRL_OFF, 8'h04);
        rd(NV_CTRL_OFF, 1'b1, "progNoPermit", 8'h00);
        wr(NV_CTRL_OFF, 8'h01);
        rd(NV_CTRL_OFF, 1'b1, "fetchNoPermit", 8'h00);
        wr(NV_CTRL_OFF, 8'h0C);
        rd(NV_CTRL_OFF, 1'b1, "permitAndGo", 8'h08);
        wr(NV_CTRL_OFF, 8'h00);
        wr(NV_IRQ_OFF, 8'h03);
        // Write cycles at both ends of the array and at random places; slow clock already runs
        for (int i = 0; i < 6; i++) begin
            addrs[i] = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
            d = 8'($urandom);
            mem[addrs[i]] = d;
            wr(NV_ADDR_OFF, {2'b00, addrs[i]});
            wr(NV_BYTE_OFF, d);
            globalIrqEnable = 1'b0;
            wr(NV_CTRL_OFF, 8'h08);
            wr(NV_CTRL_OFF, 8'h0C);
            globalIrqEnable = i[0];
            rd(NV_CTRL_OFF, 1'b1, "ctrlBusy", 8'h0C);
            wait_go_clear(PROGRAM_GO);
            rd(NV_CTRL_OFF, 1'b1, "ctrlDone", 8'h08);
            rd(NV_IRQ_OFF, 1'b1, "irqFlags", 8'h0F);
            @(negedge clk);
            compare("irqRequest", {7'h00, i[0]}, {7'h00, irqRequest});
            irqService = 1'b1;
            @(negedge clk);
            irqService = 1'b0;
            rd(NV_IRQ_OFF, 1'b1, "irqServiced", 8'h07);
            compare("irqAfterService", 8'h00, {7'h00, irqRequest});
            wr(NV_IRQ_OFF, 8'h03);
            rd(NV_IRQ_OFF, 1'b1, "irqCleared", 8'h03);
            wr(NV_CTRL_OFF, 8'h00);
        end
        // Read every written byte back, twice to see it hold
        wr(NV_CTRL_OFF, 8'h02);
        for (int i = 0; i < 6; i++) begin
            wr(NV_ADDR_OFF, {2'b00, addrs[i]});
            wr(NV_CTRL_OFF, 8'h03);
            wait_go_clear(FETCH_GO_BIT);
            rd(NV_BYTE_OFF, 1'b1, "fetched", mem[addrs[i]]);
            rd(NV_BYTE_OFF, 1'b1, "fetchedHold", mem[addrs[i]]);
        end
        // Fetch go with the permit withdrawn leaves data alone
        wr(NV_CTRL_OFF, 8'h00);
        wr(NV_ADDR_OFF, {2'b00, addrs[0]});
        wr(NV_CTRL_OFF, 8'h01);
        rd(NV_CTRL_OFF, 1'b1, "fetchBlocked", 8'h00);
        rd(NV_BYTE_OFF, 1'b1, "dataKept", mem[addrs[5]]);
        // Both go bits with both permits start a write only; shared enable off masks the request
        wr(NV_IRQ_OFF, 8'h01);
        d = 8'($urandom);
        mem[addrs[1]] = d;
        wr(NV_ADDR_OFF, {2'b00, addrs[1]});
        wr(NV_BYTE_OFF, d);
        globalIrqEnable = 1'b0;
        wr(NV_CTRL_OFF, 8'h0A);
        wr(NV_CTRL_OFF, 8'h0F);
        globalIrqEnable = 1'b1;
        rd(NV_CTRL_OFF, 1'b1, "bothGo", 8'h0E);
        wait_go_clear(PROGRAM_GO);
        rd(NV_IRQ_OFF, 1'b1, "irqMfMasked", 8'h0D);
        @(negedge clk);
        compare("irqMfMasked", 8'h00, {7'h00, irqRequest});
        wr(NV_IRQ_OFF, 8'h00);
        // Overwrite the data register, then fetch the stored byte back
        wr(NV_BYTE_OFF, ~d);
        wr(NV_CTRL_OFF, 8'h03);
        wait_go_clear(FETCH_GO_BIT);
        rd(NV_BYTE_OFF, 1'b1, "bothGoStored", mem[addrs[1]]);
        wr(NV_CTRL_OFF, 8'h00);
        // Any value other than one selects bank zero
        wr(BANK_SEL_OFF, 8'h02);
        compare("bankSelect", 8'h00, {7'h00, bankSelect});
        repeat (2) @(negedge clk);
        compare("notesLeft", 8'h00, 8'(notes.size()));
        print_verdict();
    end
endmodule
